// ### src/irofs_top.sv
// module: interrupt pin routing register, axis offset registers and offset correction
// Summary of operation
// - a routing bit of 0 sends that function's interrupt to interrupt_pin_b.
// - a routing bit of 1 sends that function's interrupt to interrupt_pin_a.
// - routing bits are 7 auto-sleep/wake, 6 fifo, 5 transient, 4 orientation, 3 pulse, 2 freefall/motion, 0 data ready.
// - after reset all routing bits are zero so every interrupt goes to interrupt_pin_b.
// - several sources may share a pin and the host reads the source status register to find them all.
// - the routing register is read and written by the host at its address.
// - each axis offset value is added to that axis to realign its zero-g output.
// - one offset lsb is worth 1.96 milli-g of correction.
// - each offset is an 8-bit two's-complement value covering about plus or minus 250 milli-g.
// - the x, y and z offset registers sit at consecutive addresses in that order.
// - every offset register resets to zero so no correction applies by default.
// - an interrupt reaches a pin only while its enable bit is set.
module irofs_top (
	// clock and reset
	input  wire  logic                 CLK,
	input  wire  logic                 SYS_RST,
	// register access
	input  wire  irofs_pkg::irofs_req_t REQ,
	output logic [7:0]                 RDATA,
	output logic                       RHIT,
	// interrupt sources and enables
	input  wire  logic [7:0]           SRC_EVENTS,
	input  wire  logic [7:0]           INT_ENABLE,
	// raw and corrected samples, data in 1.96 mg units
	input  wire  irofs_pkg::irofs_axes_t RAW,
	output irofs_pkg::irofs_axes_t     CORR,
	// interrupt pins, active high internal level
	output logic                       INT_PIN_A,
	output logic                       INT_PIN_B,
	// routing and offset register views
	output logic [7:0]                 ROUTING_Q,
	output logic [7:0]                 OFF_X_Q,
	output logic [7:0]                 OFF_Y_Q,
	output logic [7:0]                 OFF_Z_Q
);
	import irofs_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [7:0]  routing_ff;
	logic [7:0]  off_x_ff;
	logic [7:0]  off_y_ff;
	logic [7:0]  off_z_ff;
	logic [7:0]  rdata_ff;
	logic        rhit_ff;
	logic        pin_a_ff;
	logic        pin_b_ff;
	irofs_axes_t corr_ff;

	wire         sel_rt = (REQ.addr == ADDR_ROUTING);
	wire         sel_x  = (REQ.addr == ADDR_X_OFFSET);
	wire         sel_y  = (REQ.addr == ADDR_Y_OFFSET);
	wire         sel_z  = (REQ.addr == ADDR_Z_OFFSET);
	wire         hit    = sel_rt | sel_x | sel_y | sel_z;
	wire  [7:0]  nxt_routing = (REQ.wr && sel_rt) ? (REQ.wdata & ROUTING_MASK) : routing_ff;
	wire  [7:0]  nxt_off_x   = (REQ.wr && sel_x) ? REQ.wdata : off_x_ff;
	wire  [7:0]  nxt_off_y   = (REQ.wr && sel_y) ? REQ.wdata : off_y_ff;
	wire  [7:0]  nxt_off_z   = (REQ.wr && sel_z) ? REQ.wdata : off_z_ff;
	wire  [7:0]  rd_mux = sel_rt ? (routing_ff & ROUTING_MASK) :
	                      sel_x  ? off_x_ff :
	                      sel_y  ? off_y_ff :
	                      sel_z  ? off_z_ff : 8'h00;
	wire  [7:0]  nxt_rdata = REQ.rd ? rd_mux : rdata_ff;
	wire         nxt_rhit  = REQ.rd & hit;

	// ----------------------------------------
	// routing: enable gates, then bit steers
	// ----------------------------------------
	wire  [7:0]  active = SRC_EVENTS & INT_ENABLE & ROUTING_MASK;
	logic [7:0]  to_pin_a;
	logic [7:0]  to_pin_b;

	// one steering cell per source bit
	for (genvar g = 0; g < 8; g++) begin : g_steer
		assign to_pin_a[g] = active[g] & routing_ff[g];
		assign to_pin_b[g] = active[g] & ~routing_ff[g];
	end

	// any number of sources may share one pin
	wire         nxt_pin_a = |to_pin_a;
	wire         nxt_pin_b = |to_pin_b;

	// ----------------------------------------
	// offset correction, sign-extended lsb add
	// ----------------------------------------
	wire  signed [11:0] ox = {{4{off_x_ff[7]}}, off_x_ff};
	wire  signed [11:0] oy = {{4{off_y_ff[7]}}, off_y_ff};
	wire  signed [11:0] oz = {{4{off_z_ff[7]}}, off_z_ff};
	irofs_axes_t nxt_corr;
	assign nxt_corr.x = RAW.x + ox;
	assign nxt_corr.y = RAW.y + oy;
	assign nxt_corr.z = RAW.z + oz;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// routing register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			routing_ff <= ROUTING_RESET;
		end else begin
			routing_ff <= nxt_routing;
		end
	end

	// x offset register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			off_x_ff <= OFFSET_RESET;
		end else begin
			off_x_ff <= nxt_off_x;
		end
	end

	// y offset register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			off_y_ff <= OFFSET_RESET;
		end else begin
			off_y_ff <= nxt_off_y;
		end
	end

	// z offset register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			off_z_ff <= OFFSET_RESET;
		end else begin
			off_z_ff <= nxt_off_z;
		end
	end

	// read data, held until the next read
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// read hit pulse
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rhit_ff <= 1'b0;
		end else begin
			rhit_ff <= nxt_rhit;
		end
	end

	// pin a level
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pin_a_ff <= 1'b0;
		end else begin
			pin_a_ff <= nxt_pin_a;
		end
	end

	// pin b level
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pin_b_ff <= 1'b0;
		end else begin
			pin_b_ff <= nxt_pin_b;
		end
	end

	// corrected samples
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			corr_ff <= '0;
		end else begin
			corr_ff <= nxt_corr;
		end
	end

	assign RDATA     = rdata_ff;
	assign RHIT      = rhit_ff;
	assign INT_PIN_A = pin_a_ff;
	assign INT_PIN_B = pin_b_ff;
	assign CORR      = corr_ff;
	assign ROUTING_Q = routing_ff;
	assign OFF_X_Q   = off_x_ff;
	assign OFF_Y_Q   = off_y_ff;
	assign OFF_Z_Q   = off_z_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	pin_b_route_a: assert property (|(SRC_EVENTS & INT_ENABLE & ~routing_ff & ROUTING_MASK) |=> INT_PIN_B)
		else $error("enabled source routed low did not reach pin b");
	pin_a_route_a: assert property (|(SRC_EVENTS & INT_ENABLE & routing_ff & ROUTING_MASK) |=> INT_PIN_A)
		else $error("enabled source routed high did not reach pin a");
	pin_a_only_a: assert property (INT_PIN_A |-> $past(|(SRC_EVENTS & INT_ENABLE & routing_ff)))
		else $error("pin a set without an enabled routed source");
	reset_clear_a: assert property (@(posedge CLK) $past(SYS_RST) |-> (ROUTING_Q == 8'h00 && OFF_X_Q == 8'h00))
		else $error("registers not cleared by reset");
	shared_pin_a: assert property ($countones(SRC_EVENTS & ~routing_ff & ROUTING_MASK & INT_ENABLE) > 1 |=> INT_PIN_B)
		else $error("shared pin lost a source");
	rout_wr_rd_a: assert property (REQ.wr && sel_rt ##1 REQ.rd && sel_rt && !REQ.wr |=> RDATA == ($past(REQ.wdata, 2) & 8'hfd))
		else $error("routing readback mismatch");
	corr_add_a: assert property (1'b1 |=> CORR.x == $past(RAW.x) + {{4{$past(off_x_ff[7])}}, $past(off_x_ff)})
		else $error("x correction wrong");
	sign_ext_a: assert property (off_z_ff == 8'hff |=> CORR.z == $past(RAW.z) - 12'sd1)
		else $error("offset not two's complement");
	off_order_a: assert property (REQ.wr && REQ.addr == 8'h31 |=> OFF_Z_Q == $past(REQ.wdata))
		else $error("z offset address wrong");
	off_reset_a: assert property (@(posedge CLK) $past(SYS_RST) |-> (OFF_Y_Q == 8'h00 && OFF_Z_Q == 8'h00))
		else $error("offsets not zero after reset");
	enable_gate_a: assert property ((SRC_EVENTS & INT_ENABLE) == 8'h00 |=> !INT_PIN_A && !INT_PIN_B)
		else $error("pin asserted without enable");
	bit1_zero_a: assert property (ROUTING_Q[1] == 1'b0)
		else $error("unused routing bit set");
	scale_a: assert property (off_y_ff == 8'h7f |=> CORR.y == $past(RAW.y) + 12'sd127)
		else $error("offset scale out of range");

	// register access
	rhit_pulse_a: assert property (REQ.rd && hit |=> RHIT)
		else $error("mapped read gave no hit");
	rhit_idle_a: assert property (!REQ.rd |=> !RHIT)
		else $error("hit without a read");
	rdata_hold_a: assert property (!REQ.rd |=> $stable(RDATA))
		else $error("read data moved without a read");
	rhit_miss_a: assert property (REQ.rd && !hit |=> !RHIT && RDATA == 8'h00)
		else $error("unmapped read not refused");
	rout_wr_a: assert property (REQ.wr && sel_rt |=> ROUTING_Q == ($past(REQ.wdata) & ROUTING_MASK))
		else $error("routing write lost");
	rout_hold_a: assert property (!(REQ.wr && sel_rt) |=> $stable(ROUTING_Q))
		else $error("routing changed without a write");
	offx_wr_a: assert property (REQ.wr && REQ.addr == ADDR_X_OFFSET |=> OFF_X_Q == $past(REQ.wdata))
		else $error("x offset address wrong");
	offy_wr_a: assert property (REQ.wr && REQ.addr == ADDR_Y_OFFSET |=> OFF_Y_Q == $past(REQ.wdata))
		else $error("y offset address wrong");
	offx_hold_a: assert property (!(REQ.wr && sel_x) |=> $stable(OFF_X_Q))
		else $error("x offset changed without a write");
	offy_hold_a: assert property (!(REQ.wr && sel_y) |=> $stable(OFF_Y_Q))
		else $error("y offset changed without a write");
	offz_hold_a: assert property (!(REQ.wr && sel_z) |=> $stable(OFF_Z_Q))
		else $error("z offset changed without a write");
	rd_bit1_a: assert property (REQ.rd && sel_rt |=> !RDATA[1])
		else $error("unused routing bit read back set");

	// pins
	pin_b_only_a: assert property (INT_PIN_B |-> $past(|(SRC_EVENTS & INT_ENABLE & ~routing_ff & ROUTING_MASK)))
		else $error("pin b set without an enabled routed source");
	bit1_src_a: assert property (SRC_EVENTS == 8'h02 |=> !INT_PIN_A && !INT_PIN_B)
		else $error("unused source reached a pin");
	pins_reset_a: assert property ($past(SYS_RST) |-> !INT_PIN_A && !INT_PIN_B)
		else $error("pins not low after reset");

	// correction
	corr_y_a: assert property (1'b1 |=> CORR.y == $past(RAW.y) + {{4{$past(off_y_ff[7])}}, $past(off_y_ff)})
		else $error("y correction wrong");
	corr_z_a: assert property (1'b1 |=> CORR.z == $past(RAW.z) + {{4{$past(off_z_ff[7])}}, $past(off_z_ff)})
		else $error("z correction wrong");
	corr_reset_a: assert property ($past(SYS_RST) |-> CORR == '0 && RDATA == 8'h00 && !RHIT)
		else $error("outputs not cleared by reset");

	// per-source steering checks
	for (genvar s = 0; s < 8; s++) begin : g_chk
		if (ROUTING_MASK[s]) begin : g_used
			bit_to_a_a: assert property (SRC_EVENTS[s] && INT_ENABLE[s] && routing_ff[s] |=> INT_PIN_A)
				else $error("source routed high missed pin a");
			bit_to_b_a: assert property (SRC_EVENTS[s] && INT_ENABLE[s] && !routing_ff[s] |=> INT_PIN_B)
				else $error("source routed low missed pin b");
			bit_off_a: assert property (SRC_EVENTS[s] && !INT_ENABLE[s] && (SRC_EVENTS & INT_ENABLE) == 8'h00
				|=> !INT_PIN_A && !INT_PIN_B)
				else $error("disabled source reached a pin");
		end
	end

	// ----------------------------------------
	// covers
	// ----------------------------------------
	route_a_c: cover property (INT_PIN_A && INT_PIN_B);
	write_rt_c: cover property (REQ.wr && sel_rt ##1 REQ.rd && sel_rt);
	neg_off_c: cover property (off_x_ff[7] ##1 CORR.x < 0);
	reroute_c: cover property (INT_PIN_B ##1 INT_PIN_A && !INT_PIN_B);
	shared_b_c: cover property ($countones(SRC_EVENTS & INT_ENABLE & ~routing_ff & ROUTING_MASK) > 1 ##1 INT_PIN_B);
endmodule : irofs_top

// ### src/irofs_pkg.sv
// package: register map, field layout and types of the interrupt routing and offset block
package irofs_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_ROUTING  = 8'h2e;
	localparam logic [7:0] ADDR_X_OFFSET = 8'h2f;
	localparam logic [7:0] ADDR_Y_OFFSET = 8'h30;
	localparam logic [7:0] ADDR_Z_OFFSET = 8'h31;
	// ----------------------------------------
	// reset values and field layout
	// ----------------------------------------
	localparam logic [7:0] ROUTING_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET  = 8'h00;
	localparam logic [7:0] ROUTING_MASK  = 8'hfd;
	localparam int         BIT_ASLP      = 7;
	localparam int         BIT_FIFO      = 6;
	localparam int         BIT_TRANS     = 5;
	localparam int         BIT_ORIENT    = 4;
	localparam int         BIT_PULSE     = 3;
	localparam int         BIT_FF_MT     = 2;
	localparam int         BIT_UNUSED    = 1;
	localparam int         BIT_DRDY      = 0;
	// offset scale: micro-g per lsb and full range in milli-g
	localparam int         OFFSET_UG_PER_LSB = 1960;
	localparam int         OFFSET_RANGE_MG   = 250;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} irofs_req_t;

	typedef struct packed {
		logic signed [11:0] x;
		logic signed [11:0] y;
		logic signed [11:0] z;
	} irofs_axes_t;
endpackage : irofs_pkg

// ### sim/irofs_host_model.sv
// file: host model that watches both interrupt pins
module irofs_host_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// pins and sticky view
	input  wire logic       pin_a,
	input  wire logic       pin_b,
	input  wire logic       clr,
	output logic      [1:0] seen_ff
);
	// host latches every pin seen until it has read the sources
	always_ff @(posedge clk) begin
		if (rst | clr)
			seen_ff <= 2'h0;
		else
			seen_ff <= seen_ff | {pin_a, pin_b};
	end
endmodule : irofs_host_model

// ### sim/interrupt_routing_offset_regs_bench.sv
// file: self-checking bench for routing and offset registers
module interrupt_routing_offset_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import irofs_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk = 1'b0;
	logic        sys_rst, pa, pb, rhit, clr;
	logic [7:0]  rdata, src, ena, rq, ox, oy, oz, m;
	logic [1:0]  seen;
	irofs_req_t  req;
	irofs_axes_t raw, corr;
	int          fail_count = 0;
	int          n_tests = 0;
	int          bl[7] = '{7, 6, 5, 4, 3, 2, 0};
	always #20 clk = ~clk;
	irofs_top u_irofs_top (.CLK(clk), .SYS_RST(sys_rst), .REQ(req), .RDATA(rdata), .RHIT(rhit),
		.SRC_EVENTS(src), .INT_ENABLE(ena), .RAW(raw), .CORR(corr), .INT_PIN_A(pa), .INT_PIN_B(pb),
		.ROUTING_Q(rq), .OFF_X_Q(ox), .OFF_Y_Q(oy), .OFF_Z_Q(oz));
	irofs_host_model u_irofs_host_model (.clk(clk), .rst(sys_rst), .pin_a(pa), .pin_b(pb),
		.clr(clr), .seen_ff(seen));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task test_done;
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) req = '{1'b1, 1'b0, a, d};
		@(negedge clk) req = '0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) req = '0;
		chk({4'h0, e}, {4'h0, rdata});
		chk({11'h0, h}, {11'h0, rhit});
	endtask : rd
	task pins(input logic [7:0] r, input logic [7:0] s, input logic [7:0] en, input logic [1:0] e);
		wr(ADDR_ROUTING, r);
		src = s;
		ena = en;
		repeat (2) @(negedge clk);
		chk({10'h0, e}, {10'h0, pa, pb});
	endtask : pins
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#100us;
		fail_count++;
		test_done;
	end
	initial begin
		sys_rst = 1'b1; req = '0; src = 8'h00; ena = 8'h00; raw = '0; clr = 1'b0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 4; i++) rd(ADDR_ROUTING + 8'(i), 8'h00, 1'b1);
		wr(ADDR_ROUTING, 8'hff);
		rd(ADDR_ROUTING, 8'hfd, 1'b1);
		for (int i = 0; i < 3; i++) wr(ADDR_X_OFFSET + 8'(i), 8'(8'h11 * (i + 1)));
		for (int i = 0; i < 3; i++) rd(ADDR_X_OFFSET + 8'(i), 8'(8'h11 * (i + 1)), 1'b1);
		rd(8'h32, 8'h00, 1'b0);
		foreach (bl[k]) begin
			m = 8'h01 << bl[k];
			pins(m, m, 8'hff, 2'b10);
			pins(8'h00, m, 8'hff, 2'b01);
			pins(m, m, ~m, 2'b00);
		end
		pins(8'hff, 8'h02, 8'hff, 2'b00);
		clr = 1'b1;
		@(negedge clk) clr = 1'b0;
		pins(8'h00, 8'h05, 8'hff, 2'b01);
		pins(8'h80, 8'h81, 8'hff, 2'b11);
		@(negedge clk);
		chk(12'h003, {10'h0, seen});
		wr(ADDR_X_OFFSET, 8'h80);
		wr(ADDR_Y_OFFSET, 8'h7f);
		wr(ADDR_Z_OFFSET, 8'hff);
		raw = '{12'h010, 12'h000, 12'h7ff};
		repeat (2) @(negedge clk);
		chk(12'hf90, corr.x);
		chk(12'h07f, corr.y);
		chk(12'h7fe, corr.z);
		sys_rst = 1'b1;
		@(negedge clk) sys_rst = 1'b0;
		rd(ADDR_X_OFFSET, 8'h00, 1'b1);
		test_done;
	end
endmodule : interrupt_routing_offset_regs_bench
